/* design/ast_uart.sv */
// Notes on behaviour
// - character length is 5, 6, 7 or 8 data bits, both directions
// - parity bit is even, odd, absent or stuck at a fixed value
// - transmitter appends 1, 1.5 or 2 stop bit times
// - separate receive and transmit FIFOs, FIFO_DEPTH deep (16 by default) in both variants
// - idle gap of tx_gap_delay plus one bit times between characters, none when tx_gap_delay is zero
// - receive time-out after an 8-bit programmed idle count with data waiting
// - threshold flag when receive fill level reaches the trigger level
// - flag break, framing, parity errors and buffer overflow
// - IrDA transmit pulses last three sixteenths of a bit
// - RS-485 mode uses nine-bit characters, ninth bit marks addresses
// - RS-485 direction on request_to_send_n, automatic or by software
// - clear_to_send_n paces transmit; request_to_send_n follows rx space
// - wake on cts change, rx data, threshold, timeout or address match
// - auto-baud measurement of incoming rate plus baud compensation
// - each channel has its own baud-rate generator
// - single-wire mode shares one line for transmit and receive
// - DMA requests for transmit and receive data
// - reduced variant drops cts, threshold, timeout, address wake, comp
// - ten distinct event sources
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module ast_uart #(
  parameter int FIFO_DEPTH = 16,
  parameter bit FULL_FEATURE = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rxd_in,
  input wire logic cts_n_in,
  input wire logic sw_in,
  output logic txd_out,
  output logic rts_n_out,
  output logic sw_out,
  output logic sw_oe_out,
  output logic wake_out,
  output logic dma_tx_req_out,
  output logic dma_rx_req_out,
  output logic [ast_pkg::N_EVT-1:0] events_out
);
  import ast_pkg::*;
  localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (32'(p) == FIFO_DEPTH - 1) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  function automatic logic par_of(input logic [7:0] d, input logic even,
                                  input logic stick);
    par_of = stick ? ~even : (even ? ^d : ~^d);
  endfunction : par_of

  logic [31:0] lcr_ff, mode_ff, baud_ff, tout_ff, wake_en_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, rd_ok_ff;
  logic [1:0] rxd_sy_ff, cts_sy_ff, sw_sy_ff;
  logic cts_prev_ff, rxl_prev_ff;
  logic [4:0] ir_hold_ff;
  logic [15:0] bcnt_ff;
  logic [3:0] ph_ff;
  logic tick_ff;
  logic [8:0] rxm [FIFO_DEPTH];
  logic [8:0] txm [FIFO_DEPTH];
  logic [PW-1:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff;
  logic [4:0] rx_cnt_ff, tx_cnt_ff;
  ast_rx_type rx_st_ff;
  ast_tx_type tx_st_ff;
  logic [3:0] rx_tc_ff, rx_bn_ff, tx_bn_ff;
  logic [9:0] rx_sh_ff;
  logic [10:0] tx_sh_ff;
  logic [12:0] tx_tc_ff;
  logic [11:0] tocnt_ff;
  logic match_ff, abr_run_ff;
  logic [19:0] abr_cnt_ff;
  logic [N_EVT-1:0] stat_ff;
  logic txd_ff, rts_ff, sw_out_ff, sw_oe_ff, wake_ff, dtx_ff, drx_ff;

  // bus decode
  wire apb_acc = psel_in & penable_in & ~pready_ff;
  wire apb_done = psel_in & penable_in & pready_ff;
  wire wr_en = apb_done & pwrite_in;
  wire rd_en = apb_done & ~pwrite_in;
  wire hit_data = paddr_in == OFS_DATA;
  wire hit_lcr = paddr_in == OFS_LCR;
  wire hit_mode = paddr_in == OFS_MODE;
  wire hit_baud = paddr_in == OFS_BAUD;
  wire hit_tout = paddr_in == OFS_TOUT;
  wire hit_stat = paddr_in == OFS_STAT;
  wire hit_lvl = paddr_in == OFS_LVL;
  wire hit_wake = paddr_in == OFS_WAKE;
  wire mapped = |{hit_data, hit_lcr, hit_mode, hit_baud, hit_tout,
                  hit_stat, hit_lvl, hit_wake};

  // configuration
  wire [1:0] fn = mode_ff[1:0];
  wire is_irda = fn == FN_IRDA;
  wire is_485 = fn == FN_RS485;
  wire is_sw = fn == FN_SWIRE;
  wire nine = is_485;
  wire [3:0] dbits = nine ? 4'h8 : 4'h5 + {2'h0, lcr_ff[1:0]};
  wire pen = lcr_ff[LCR_PEN];
  wire epe = lcr_ff[LCR_EPE];
  wire stick = lcr_ff[LCR_STICK];
  wire [3:0] nb = dbits + {3'h0, nine} + {3'h0, pen};
  wire [5:0] stop_t = !lcr_ff[LCR_STOP2] ? STOP1_TICKS :
                      (dbits == 4'h5 ? STOP15_TICKS : STOP2_TICKS);
  wire [7:0] addr = mode_ff[MODE_ADDR+:8];
  wire aad_on = is_485 & mode_ff[MODE_AAD];

  // receive line: irda pulses are stretched to a full bit before sampling
  wire raw_rx = is_sw ? sw_sy_ff[1] : rxd_sy_ff[1];
  wire rxl = is_irda ? (ir_hold_ff == 5'h0) : raw_rx;
  wire cts_chg = cts_sy_ff[1] ^ cts_prev_ff;
  wire rx_fall = rxl_prev_ff & ~rxl;

  // baud generator; compensation stretches the first comp ticks of 16
  wire [3:0] comp = FULL_FEATURE ? mode_ff[MODE_COMP+:4] : 4'h0;
  wire [15:0] bdiv = baud_ff[15:0] + {15'h0, ph_ff < comp};

  // fifo status
  wire rx_full = rx_cnt_ff == 5'(FIFO_DEPTH);
  wire rx_empty = rx_cnt_ff == 5'h0;
  wire tx_full = tx_cnt_ff == 5'(FIFO_DEPTH);
  wire tx_empty = tx_cnt_ff == 5'h0;
  wire [8:0] rx_head = rx_empty ? 9'h0 : rxm[rx_rp_ff];
  wire [8:0] tx_word = txm[tx_rp_ff];
  wire rx_pop = rd_en & hit_data & rd_ok_ff;
  wire tx_push = wr_en & hit_data & ~tx_full;
  wire rx_thr = ~rx_empty &
                (rx_cnt_ff >= {1'b0, lcr_ff[LCR_TRIG+:4]});

  // received frame decode
  wire rx_smp = rx_st_ff == RX_STOP && tick_ff && rx_tc_ff == 4'hF;
  wire [9:0] rx_raw = rx_sh_ff >> (4'hA - nb);
  wire [7:0] rx_dat = rx_raw[7:0] & (8'hFF >> (4'h8 - dbits));
  wire rx_nin = nine & rx_raw[8];
  wire rx_pbit = rx_raw[dbits + {3'h0, nine}];
  wire par_ev = rx_smp & pen & (rx_pbit != par_of(rx_dat, epe, stick));
  wire frm_ev = rx_smp & ~rxl;
  wire brk_ev = frm_ev & (rx_raw == 10'h0);
  // matching address bytes open the gate, others close it; data bytes pass only while it is open
  wire addr_hit = rx_smp & aad_on & rx_nin & (rx_dat == addr);
  wire rx_acc = ~aad_on | (rx_nin ? rx_dat == addr : match_ff);
  wire rx_push = rx_smp & rx_acc;
  wire rx_wr = rx_push & ~rx_full;
  wire [11:0] to_lim = {tout_ff[7:0], 4'h0};
  wire to_run = ~rx_empty & rx_st_ff == RX_IDLE & to_lim != 12'h0;
  wire tout_ev = tick_ff & to_run & tocnt_ff == to_lim - 12'h1;

  // transmit frame build: start bit at the lsb, data lsb first
  wire cts_ok = ~mode_ff[MODE_ACTS] | ~cts_sy_ff[1];
  wire tx_go = tx_st_ff == TX_IDLE & ~tx_empty & cts_ok;
  wire [7:0] tx_dm = tx_word[7:0] & (8'hFF >> (4'h8 - dbits));
  wire tx_par = pen & par_of(tx_dm, epe, stick);
  wire [9:0] tx_fr = {2'h0, tx_dm} | (10'(nine & tx_word[8]) << dbits) |
                     (10'(tx_par) << (dbits + {3'h0, nine}));
  wire tx_frame = tx_st_ff == TX_BITS | tx_st_ff == TX_STOP;
  wire tx_line = tx_st_ff == TX_BITS ? tx_sh_ff[0] : 1'b1;
  wire [12:0] gap_end = {1'b0, tout_ff[15:8], 4'hF};

  wire abr_done = abr_run_ff & rxl;
  wire [19:0] abr_q = abr_cnt_ff >> 4;
  wire [15:0] abr_div = abr_q[15:0] - 16'h1;
  wire ovf_ev = (rx_push & rx_full) | (wr_en & hit_data & tx_full);
  wire txe_ev = tx_go & tx_cnt_ff == 5'h1;
  wire [N_EVT-1:0] ev_set = {abr_done, cts_chg, ovf_ev, brk_ev, frm_ev,
                             par_ev, tout_ev, rx_thr, txe_ev, rx_wr};
  wire [N_EVT-1:0] ev_clr = (wr_en & hit_stat) ? pwdata_in[N_EVT-1:0] : '0;
  // reduced channel keeps only incoming-data wake
  wire [4:0] wk_mask = FULL_FEATURE ? 5'h1F : 5'h02;
  wire [4:0] wk_src = {tout_ev, addr_hit, rx_thr, rx_fall, cts_chg};
  wire [31:0] rd_mux =
    hit_data ? {23'h0, rx_head} :
    hit_lcr ? lcr_ff :
    hit_mode ? mode_ff :
    hit_baud ? baud_ff :
    hit_tout ? tout_ff :
    hit_stat ? {12'h0, rts_ff, cts_sy_ff[1], rx_st_ff != RX_IDLE,
                tx_st_ff != TX_IDLE, 6'h0, stat_ff} :
    hit_lvl ? {19'h0, tx_cnt_ff, 3'h0, rx_cnt_ff} :
    hit_wake ? wake_en_ff : 32'h0;

  // apb: answer in the second access cycle
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
      rd_ok_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= apb_acc;
      pslverr_ff <= apb_acc & ~mapped;
      prdata_ff <= (apb_acc & ~pwrite_in) ? rd_mux : 32'h0;
      rd_ok_ff <= apb_acc & ~rx_empty;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      lcr_ff <= LCR_RST;
      mode_ff <= MODE_RST;
      baud_ff <= BAUD_RST;
      tout_ff <= TOUT_RST;
      wake_en_ff <= WAKE_RST;
      stat_ff <= '0;
    end
    else
    begin
      if (wr_en & hit_lcr) lcr_ff <= pwdata_in;
      if (wr_en & hit_tout) tout_ff <= pwdata_in;
      if (wr_en & hit_wake) wake_en_ff <= pwdata_in;
      if (wr_en & hit_mode) mode_ff <= pwdata_in;
      else if (abr_done) mode_ff[MODE_ABR] <= 1'b0;
      if (wr_en & hit_baud) baud_ff <= pwdata_in;
      else if (abr_done) baud_ff <= {16'h0, abr_div};
      // a new event beats a clear in the same cycle
      stat_ff <= (stat_ff & ~ev_clr) | ev_set;
    end
  end

  // synchronisers and auto-baud measurement
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rxd_sy_ff <= 2'h3;
      cts_sy_ff <= 2'h3;
      sw_sy_ff <= 2'h3;
      cts_prev_ff <= 1'b1;
      rxl_prev_ff <= 1'b1;
      ir_hold_ff <= 5'h0;
      abr_run_ff <= 1'b0;
      abr_cnt_ff <= 20'h0;
    end
    else
    begin
      rxd_sy_ff <= {rxd_sy_ff[0], rxd_in};
      cts_sy_ff <= {cts_sy_ff[0], cts_n_in};
      sw_sy_ff <= {sw_sy_ff[0], sw_in};
      cts_prev_ff <= cts_sy_ff[1];
      rxl_prev_ff <= rxl;
      if (raw_rx) ir_hold_ff <= 5'h10;
      else if (tick_ff && ir_hold_ff != 5'h0) ir_hold_ff <= ir_hold_ff - 5'h1;
      // the start bit is timed; the sender should make data bit 0 high
      if (abr_done) abr_run_ff <= 1'b0;
      else if (mode_ff[MODE_ABR] & rx_fall) abr_run_ff <= 1'b1;
      if (!abr_run_ff) abr_cnt_ff <= 20'h0;
      else if (abr_cnt_ff != 20'hFFFFF) abr_cnt_ff <= abr_cnt_ff + 20'h1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      bcnt_ff <= 16'h0;
      ph_ff <= 4'h0;
      tick_ff <= 1'b0;
    end
    else if (bcnt_ff >= bdiv)
    begin
      bcnt_ff <= 16'h0;
      ph_ff <= ph_ff + 4'h1;
      tick_ff <= 1'b1;
    end
    else
    begin
      bcnt_ff <= bcnt_ff + 16'h1;
      tick_ff <= 1'b0;
    end
  end

  // fifo storage needs no reset; pointers and counts do
  always_ff @(posedge clk_in)
  begin
    if (rx_wr) rxm[rx_wp_ff] <= {rx_nin, rx_dat};
    if (tx_push) txm[tx_wp_ff] <= pwdata_in[8:0];
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      tx_wp_ff <= '0;
      tx_rp_ff <= '0;
      rx_cnt_ff <= 5'h0;
      tx_cnt_ff <= 5'h0;
    end
    else
    begin
      if (rx_wr) rx_wp_ff <= ptr_inc(rx_wp_ff);
      if (rx_pop) rx_rp_ff <= ptr_inc(rx_rp_ff);
      if (tx_push) tx_wp_ff <= ptr_inc(tx_wp_ff);
      if (tx_go) tx_rp_ff <= ptr_inc(tx_rp_ff);
      rx_cnt_ff <= rx_cnt_ff + 5'(rx_wr) - 5'(rx_pop);
      tx_cnt_ff <= tx_cnt_ff + 5'(tx_push) - 5'(tx_go);
    end
  end

  // receiver: centre of start bit, then one sample every 16 ticks
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      rx_st_ff <= RX_IDLE;
      rx_tc_ff <= 4'h0;
      rx_bn_ff <= 4'h0;
      rx_sh_ff <= 10'h0;
      match_ff <= 1'b0;
      tocnt_ff <= 12'h0;
    end
    else
    begin
      case (rx_st_ff)
        RX_IDLE:
          if (!rxl)
          begin
            rx_st_ff <= RX_START;
            rx_tc_ff <= 4'h0;
          end
        RX_START:
          if (tick_ff)
          begin
            rx_tc_ff <= rx_tc_ff + 4'h1;
            if (rx_tc_ff == 4'h7)
            begin
              rx_st_ff <= rxl ? RX_IDLE : RX_BITS;
              rx_tc_ff <= 4'h0;
              rx_bn_ff <= 4'h0;
              rx_sh_ff <= 10'h0;
            end
          end
        RX_BITS:
          if (tick_ff)
          begin
            rx_tc_ff <= rx_tc_ff + 4'h1;
            if (rx_tc_ff == 4'hF)
            begin
              rx_sh_ff <= {rxl, rx_sh_ff[9:1]};
              rx_bn_ff <= rx_bn_ff + 4'h1;
              if (rx_bn_ff == nb - 4'h1) rx_st_ff <= RX_STOP;
            end
          end
        RX_STOP:
          if (tick_ff)
          begin
            rx_tc_ff <= rx_tc_ff + 4'h1;
            if (rx_tc_ff == 4'hF) rx_st_ff <= RX_IDLE;
          end
        default: rx_st_ff <= RX_IDLE;
      endcase
      if (rx_smp & aad_on & rx_nin) match_ff <= rx_dat == addr;
      // a limit shortened by software must not strand the count above it
      if (rx_wr | rx_pop | ~to_run | tocnt_ff > to_lim) tocnt_ff <= 12'h0;
      else if (tick_ff && tocnt_ff != to_lim) tocnt_ff <= tocnt_ff + 12'h1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      tx_st_ff <= TX_IDLE;
      tx_tc_ff <= 13'h0;
      tx_bn_ff <= 4'h0;
      tx_sh_ff <= 11'h7FF;
    end
    else
    begin
      case (tx_st_ff)
        TX_IDLE:
          if (tx_go)
          begin
            tx_sh_ff <= {tx_fr, 1'b0};
            tx_tc_ff <= 13'h0;
            tx_bn_ff <= 4'h0;
            tx_st_ff <= TX_BITS;
          end
        TX_BITS:
          if (tick_ff)
          begin
            if (tx_tc_ff[3:0] == 4'hF)
            begin
              tx_tc_ff <= 13'h0;
              tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
              tx_bn_ff <= tx_bn_ff + 4'h1;
              if (tx_bn_ff == nb) tx_st_ff <= TX_STOP;
            end
            else tx_tc_ff <= tx_tc_ff + 13'h1;
          end
        TX_STOP:
          if (tick_ff)
          begin
            if (tx_tc_ff == {7'h0, stop_t - 6'h1})
            begin
              tx_tc_ff <= 13'h0;
              tx_st_ff <= (tout_ff[15:8] == 8'h0) ? TX_IDLE : TX_GAP;
            end
            else tx_tc_ff <= tx_tc_ff + 13'h1;
          end
        TX_GAP:
          if (tick_ff)
          begin
            if (tx_tc_ff == gap_end) tx_st_ff <= TX_IDLE;
            else tx_tc_ff <= tx_tc_ff + 13'h1;
          end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // pins and request outputs, all registered
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      txd_ff <= 1'b1;
      rts_ff <= 1'b1;
      sw_out_ff <= 1'b1;
      sw_oe_ff <= 1'b0;
      wake_ff <= 1'b0;
      dtx_ff <= 1'b0;
      drx_ff <= 1'b0;
    end
    else
    begin
      // irda idles low and sends a short high pulse for each zero bit
      txd_ff <= is_irda ? ~tx_line & (tx_tc_ff < IRDA_TICKS) :
                tx_line;
      sw_out_ff <= tx_line;
      sw_oe_ff <= is_sw & tx_frame;
      if (is_485 & mode_ff[MODE_AUTO_DIR]) rts_ff <= ~tx_frame;
      else if (mode_ff[MODE_ARTS]) rts_ff <= rx_thr;
      else rts_ff <= ~mode_ff[MODE_RTS_SW];
      wake_ff <= |(wake_en_ff[4:0] & wk_src & wk_mask);
      dtx_ff <= mode_ff[MODE_DMA_TX] & ~tx_full;
      drx_ff <= mode_ff[MODE_DMA_RX] & ~rx_empty;
    end
  end

  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign txd_out = txd_ff;
  assign rts_n_out = rts_ff;
  assign sw_out = sw_out_ff;
  assign sw_oe_out = sw_oe_ff;
  assign wake_out = wake_ff;
  assign dma_tx_req_out = dtx_ff;
  assign dma_rx_req_out = drx_ff;
  assign events_out = stat_ff;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_fifo_bound;
    rx_cnt_ff <= 5'(FIFO_DEPTH) && tx_cnt_ff <= 5'(FIFO_DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound)
    else $error("fifo count beyond depth");
  property p_stop_len;
    tx_st_ff == TX_STOP |-> tx_tc_ff < {7'h0, stop_t};
  endproperty
  a_stop_len: assert property (p_stop_len)
    else $error("stop period too long");
  property p_gap_high;
    (tx_st_ff == TX_GAP && fn == FN_UART) |=> txd_out;
  endproperty
  a_gap_high: assert property (p_gap_high)
    else $error("line not idle in gap");
  property p_tout_lim;
    $stable(tout_ff) |-> tocnt_ff <= to_lim;
  endproperty
  a_tout_lim: assert property (p_tout_lim)
    else $error("timeout count overran");
  property p_thr_flag;
    rx_thr |=> events_out[EV_THR];
  endproperty
  a_thr_flag: assert property (p_thr_flag)
    else $error("threshold not flagged");
  property p_ovf_flag;
    (rx_push && rx_full) |=> events_out[EV_OVF] &&
      rx_cnt_ff == $past(rx_cnt_ff) - 5'($past(rx_pop));
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow lost or stored");
  property p_irda_pulse;
    (is_irda && $past(is_irda) && txd_out) |-> $past(tx_tc_ff) < IRDA_TICKS;
  endproperty
  a_irda_pulse: assert property (p_irda_pulse)
    else $error("irda pulse too wide");
  property p_dir;
    (is_485 && mode_ff[MODE_AUTO_DIR] && tx_st_ff == TX_BITS) |=> !rts_n_out;
  endproperty
  a_dir: assert property (p_dir)
    else $error("rs485 direction not driven");
  property p_cts_hold;
    (tx_st_ff == TX_IDLE && mode_ff[MODE_ACTS] && cts_sy_ff[1])
      |=> tx_st_ff == TX_IDLE;
  endproperty
  a_cts_hold: assert property (p_cts_hold)
    else $error("sent while peer not clear");
  property p_start_low;
    (tx_st_ff == TX_BITS && tx_bn_ff == 4'h0 && fn == FN_UART) |=> !txd_out;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");
endmodule : ast_uart

/* common/ast_pkg.sv */
package ast_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_LCR = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0C;
  localparam logic [7:0] OFS_TOUT = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_LVL = 8'h18;
  localparam logic [7:0] OFS_WAKE = 8'h1C;
  // values after reset
  localparam logic [31:0] LCR_RST = 32'h0000_0003;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] BAUD_RST = 32'h0000_0103;
  localparam logic [31:0] TOUT_RST = 32'h0000_0040;
  localparam logic [31:0] WAKE_RST = 32'h0000_0000;
  // line control fields
  localparam int LCR_STOP2 = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPE = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_TRIG = 8;
  // mode fields
  localparam int MODE_ACTS = 2;
  localparam int MODE_ARTS = 3;
  localparam int MODE_RTS_SW = 4;
  localparam int MODE_AUTO_DIR = 5;
  localparam int MODE_AAD = 6;
  localparam int MODE_DMA_TX = 7;
  localparam int MODE_DMA_RX = 8;
  localparam int MODE_ABR = 9;
  localparam int MODE_ADDR = 16;
  localparam int MODE_COMP = 24;
  // sticky event bits
  localparam int EV_RDA = 0;
  localparam int EV_TXE = 1;
  localparam int EV_THR = 2;
  localparam int EV_TOUT = 3;
  localparam int EV_OVF = 7;
  localparam int N_EVT = 10;
  // bit timing in oversample ticks
  localparam logic [5:0] STOP1_TICKS = 6'h10;
  localparam logic [5:0] STOP15_TICKS = 6'h18;
  localparam logic [5:0] STOP2_TICKS = 6'h20;
  localparam logic [12:0] IRDA_TICKS = 13'h0003;
  typedef enum logic [1:0] {FN_UART, FN_IRDA, FN_RS485, FN_SWIRE} ast_fn_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} ast_rx_type;
  typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_STOP, TX_GAP} ast_tx_type;
endpackage : ast_pkg

/* test/ast_peer_model.sv */
`timescale 1ns/1ps
module ast_peer_model (
  input wire logic clk_in,
  input wire logic txd_in,
  output logic rxd_out,
  output logic cts_n_out
);
  // 16 ticks a bit with the divider at zero
  localparam int BIT_CYC = 16;

  initial
  begin
    rxd_out <= 1'b1;
    cts_n_out <= 1'b0;
  end

  // n payload bits lsb first, then a stop bit of the given level
  task automatic send(input logic [9:0] bits, input int n, input logic stop);
    rxd_out <= 1'b0;
    repeat (BIT_CYC) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      rxd_out <= bits[i];
      repeat (BIT_CYC) @(posedge clk_in);
    end
    rxd_out <= stop;
    repeat (BIT_CYC) @(posedge clk_in);
    rxd_out <= 1'b1;
    @(posedge clk_in);
  endtask : send

  // samples mid-bit; bits[n] is the first stop bit
  task automatic recv(input int n, output logic [9:0] bits);
    int w;
    bits = '0;
    w = 0;
    while (txd_in !== 1'b0 && w < 4000)
    begin
      @(posedge clk_in);
      w++;
    end
    repeat (BIT_CYC / 2) @(posedge clk_in);
    for (int i = 0; i <= n; i++)
    begin
      repeat (BIT_CYC) @(posedge clk_in);
      bits[i] = txd_in;
    end
  endtask : recv
endmodule : ast_peer_model

/* test/test_ast_uart.sv */
`timescale 1ns/1ps
module test_ast_uart;
  import ast_pkg::*;
  localparam int LIMIT = 20000;
  logic clk_in, rst_n_in, psel, penable, pwrite, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic pready, pslverr, txd, rts_n, sw_out, sw_oe, wake;
  logic dma_tx, dma_rx, cts_n, rxd, sw_line;
  logic [N_EVT-1:0] events;
  logic [9:0] f;
  logic [31:0] lcr_tab [4] = '{32'h18, 32'h08, 32'h28, 32'h38};
  logic [9:0] frm_tab [4] = '{10'h075, 10'h055, 10'h075, 10'h055};
  int n_mismatch, tests_run, cycles;
  logic wake_seen = 1'b0;

  ast_uart #(.FIFO_DEPTH(16), .FULL_FEATURE(1'b1)) ast_uart_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .rxd_in(rxd), .cts_n_in(cts_n),
    .sw_in(sw_line), .txd_out(txd), .rts_n_out(rts_n), .sw_out(sw_out),
    .sw_oe_out(sw_oe), .wake_out(wake), .dma_tx_req_out(dma_tx),
    .dma_rx_req_out(dma_rx), .events_out(events));

  ast_peer_model ast_peer_model_inst (
    .clk_in(clk_in), .txd_in(txd), .rxd_out(rxd), .cts_n_out(cts_n));

  initial clk_in = 1'b0;
  always #12.5 clk_in = ~clk_in;

  task automatic summarize();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input string name, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(name, exp, q & m);
  endtask : rdchk

  // cycle count for the run ceiling; one-cycle wake pulses are caught here
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (wake) wake_seen <= 1'b1;
  end

  task automatic run_tests();
    rst_n_in <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    sw_line <= 1'b1;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rdchk("lcr_rst", OFS_LCR, 32'hFFFF_FFFF, LCR_RST);
    rdchk("mode_rst", OFS_MODE, 32'hFFFF_FFFF, MODE_RST);
    rdchk("baud_rst", OFS_BAUD, 32'hFFFF_FFFF, BAUD_RST);
    rdchk("tout_rst", OFS_TOUT, 32'hFFFF_FFFF, TOUT_RST);
    rdchk("wake_rst", OFS_WAKE, 32'hFFFF_FFFF, WAKE_RST);
    rdchk("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, e});
    // fastest divider keeps each frame at or below 160 cycles
    wr(OFS_BAUD, 32'h0000_0000);
    wr(OFS_LCR, 32'h0000_0203);
    wr(OFS_MODE, 32'h0000_0180);
    // the request flop follows the mode write one edge later
    @(posedge clk_in);
    chk("dma_tx", 32'h1, {31'h0, dma_tx});
    wr(OFS_DATA, 32'h0000_00A5);
    ast_peer_model_inst.recv(8, f);
    chk("tx_8n1", 32'h1A5, {22'h0, f});
    ast_peer_model_inst.send(10'h03C, 8, 1'b1);
    chk("ev_rda", 32'h1, {31'h0, events[EV_RDA]});
    chk("thr_one", 32'h0, {31'h0, events[EV_THR]});
    ast_peer_model_inst.send(10'h0C3, 8, 1'b1);
    chk("thr_two", 32'h1, {31'h0, events[EV_THR]});
    chk("dma_rx", 32'h1, {31'h0, dma_rx});
    rdchk("rx_level", OFS_LVL, 32'h1F, 32'h2);
    rdchk("rx_first", OFS_DATA, 32'hFF, 32'h3C);
    rdchk("rx_second", OFS_DATA, 32'hFF, 32'hC3);
    rdchk("rx_empty", OFS_DATA, 32'hFFFF_FFFF, 32'h0);
    chk("dma_rx_off", 32'h0, {31'h0, dma_rx});
    wr(OFS_STAT, 32'h0000_03FF);
    // 5 data bits through even, odd and both stick parities
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_LCR, lcr_tab[i]);
      wr(OFS_DATA, 32'h0000_0015);
      ast_peer_model_inst.recv(6, f);
      chk("tx_parity", {22'h0, frm_tab[i]}, {22'h0, f});
    end
    // five bit times of gap keep the line high well past the stop bit
    wr(OFS_TOUT, 32'h0000_0440);
    wr(OFS_DATA, 32'h0000_0015);
    wr(OFS_DATA, 32'h0000_0015);
    ast_peer_model_inst.recv(6, f);
    repeat (16) @(posedge clk_in);
    chk("gap_idle", 32'h1, {31'h0, txd});
    ast_peer_model_inst.recv(6, f);
    chk("tx_after_gap", 32'h055, {22'h0, f});
    wr(OFS_LCR, 32'h0000_0018);
    wr(OFS_WAKE, 32'h0000_0002);
    ast_peer_model_inst.send(10'h035, 6, 1'b1);
    rdchk("rx_5e1", OFS_DATA, 32'hFF, 32'h15);
    rdchk("no_error", OFS_STAT, 32'h30, 32'h0);
    ast_peer_model_inst.send(10'h015, 6, 1'b1);
    rdchk("parity_err", OFS_STAT, 32'h10, 32'h10);
    ast_peer_model_inst.send(10'h035, 6, 1'b0);
    rdchk("frame_err", OFS_STAT, 32'h20, 32'h20);
    chk("wake", 32'h1, {31'h0, wake_seen});
    // single-wire: the shared line stays driven through the stop bit
    wr(OFS_MODE, 32'h0000_0003);
    wr(OFS_DATA, 32'h0000_0015);
    ast_peer_model_inst.recv(6, f);
    chk("sw_frame", 32'h075, {22'h0, f});
    chk("sw_oe", 32'h1, {31'h0, sw_oe});
    wr(OFS_MODE, 32'h0000_0010);
    @(posedge clk_in);
    chk("rts_sw", 32'h0, {31'h0, rts_n});
  endtask : run_tests

  initial
  begin
    n_mismatch = 0;
    tests_run = 0;
    fork
      run_tests();
      begin
        wait (cycles == LIMIT);
        n_mismatch++;
      end
    join_any
    summarize();
  end
endmodule : test_ast_uart
